// ==== rtl/drr_refresh_ctrl.sv ====
// Functional notes
// - tcr on: refresh period within 3.9 us
// - write rate mode before any refresh
// - reset default is fixed normal rate
// - refresh type must match fixed mode
// - new interval applies from each refresh
// - double rate: even count before rate change
// - dynamic double: even fast between normals
// - quad rate: multiple of four before change
// - dynamic quad: four-multiple fast between normals
// - fixed/dynamic swap, same rate, no change
// - tcr only with fixed normal mode
// - odd double count: extra refreshes after exit
// - quad misaligned: extra refreshes after exit
// - self refresh entry pin encoding
// - enter self refresh only when idle
// - hold cke low during self refresh
// - only deselect during refresh cycle time
// - range bit counts only with tcr on
// - refresh command pin encoding
`timescale 1ns/100ps
`default_nettype none
module drr_refresh_ctrl
   import drr_pkg::*;
#(
   parameter int ADDR_W = 12
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output drr_cmd_type dram_cmd
);

   logic [7:0] ctrl;
   drr_state_type state;
   drr_state_type next_state;
   drr_action_type action;
   drr_cmd_type next_cmd;
   logic [2:0] cur_mode;
   logic applied_tcr;
   logic applied_ext;
   logic init_mr3;
   logic init_mr4;
   logic [1:0] fast_cnt;
   logic [2:0] extra_cnt;
   logic sr_misaligned;
   logic last_fast;
   logic [15:0] ref_total;
   logic wait_done;
   logic wait_load;
   logic [7:0] wait_value;
   logic interval_done;
   logic interval_load;
   logic [7:0] interval_value;
   logic [2:0] req_mode;
   logic tcr_target;
   logic mr3_dirty;
   logic mr4_dirty;
   logic [1:0] cur_rate;
   logic rate_change;
   logic cur_aligned;
   logic ref_fast;
   logic is_ref;
   logic [31:0] status_word;
   logic [31:0] read_word;
   logic addr_hit;

   // rate of a mode: 0 normal, 1 double, 2 quad
   function automatic logic [1:0] rate_of(input logic [2:0] m);
      if (m[1:0] == 2'h1)
         return 2'h1;
      else if (m[1:0] == 2'h2)
         return 2'h2;
      else
         return 2'h0;
   endfunction

   // fast count is whole normal refreshes worth
   function automatic logic aligned(input logic [1:0] r,
      input logic [1:0] c);
      if (r == 2'h1)
         return !c[0];
      else if (r == 2'h2)
         return (c == 2'h0);
      else
         return 1'b1;
   endfunction

   // refresh cycle time per refresh rate
   function automatic logic [7:0] rfc_of(input logic [1:0] r);
      if (r == 2'h1)
         return RFC2_CYC;
      else if (r == 2'h2)
         return RFC4_CYC;
      else
         return RFC1_CYC;
   endfunction

   // average interval per rate, the tcr interval for every rate when tcr is on
   function automatic logic [7:0] refi_of(input logic [1:0] r,
      input logic temp_scaled_refresh_mode);
      if (temp_scaled_refresh_mode)
         return TCR_CYC;
      else if (r == 2'h1)
         return REFI2_CYC;
      else if (r == 2'h2)
         return REFI4_CYC;
      else
         return REFI1_CYC;
   endfunction

   // requested settings against applied ones
   assign req_mode = ctrl[CTRL_MODE_LSB +: 3];
   assign tcr_target = ctrl[CTRL_TCR_EN_BIT] &&
      (req_mode == MODE_FIXED_1X);
   assign mr3_dirty = init_mr3 || (req_mode != cur_mode);
   assign mr4_dirty = init_mr4 || (tcr_target != applied_tcr) ||
      (ctrl[CTRL_TCR_EXT_BIT] != applied_ext);
   assign cur_rate = rate_of(cur_mode);
   assign rate_change = (rate_of(req_mode) != cur_rate);
   assign cur_aligned = aligned(cur_rate, fast_cnt);
   // dynamic mode stays fast until the count is whole
   assign ref_fast = cur_mode[2] ?
      (ctrl[CTRL_USE_FAST_BIT] || !cur_aligned) : (cur_rate != 2'h0);
   assign is_ref = dram_cmd.cke && !dram_cmd.cs_n && !dram_cmd.ras_n &&
      !dram_cmd.cas_n && dram_cmd.we_n;

   // pick the next command when the bus is free
   always_comb
   begin
      action = ACT_NONE;
      if (state == ST_SELF)
      begin
         if (!ctrl[CTRL_SR_REQ_BIT])
            action = ACT_EXIT;
      end
      else if (state == ST_IDLE)
      begin
         if (mr4_dirty && !tcr_target)
            action = ACT_MR4;
         else if (mr3_dirty && rate_change && !cur_aligned)
            action = ACT_ALIGN;
         else if (mr3_dirty)
            action = ACT_MR3;
         else if (mr4_dirty)
            action = ACT_MR4;
         else if (extra_cnt != 3'h0)
            action = ACT_EXTRA;
         else if (ctrl[CTRL_SR_REQ_BIT])
            action = ACT_SRE;
         else if (ctrl[CTRL_REF_EN_BIT] && interval_done)
            action = ACT_REF;
      end
   end

   // pin values, timer loads and next state for the action
   always_comb
   begin
      next_cmd = CMD_DES;
      next_state = state;
      wait_load = 1'b0;
      wait_value = 8'h00;
      interval_load = 1'b0;
      interval_value = refi_of(cur_rate, applied_tcr);
      case (action)
         ACT_MR4:
         begin
            next_cmd = CMD_MRS;
            next_cmd.bank_group_bit_zero = MR4_BG0;
            next_cmd.ba = MR4_BA;
            next_cmd.addr[MR4_TCR_BIT] = tcr_target;
            next_cmd.addr[MR4_RANGE_BIT] = ctrl[CTRL_TCR_EXT_BIT];
            wait_load = 1'b1;
            wait_value = MOD_CYC;
         end
         ACT_MR3:
         begin
            next_cmd = CMD_MRS;
            next_cmd.bank_group_bit_zero = MR3_BG0;
            next_cmd.ba = MR3_BA;
            next_cmd.addr[MR3_RATE_LSB +: 3] = req_mode;
            wait_load = 1'b1;
            wait_value = MOD_CYC;
         end
         ACT_ALIGN, ACT_REF:
         begin
            next_cmd = CMD_REF;
            next_cmd.bank_group_bit_zero = cur_mode[2] && ref_fast;
            wait_load = 1'b1;
            wait_value = rfc_of(ref_fast ? cur_rate : 2'h0);
            interval_load = 1'b1;
            interval_value = refi_of(ref_fast ? cur_rate : 2'h0,
               applied_tcr);
         end
         ACT_EXTRA:
         begin
            next_cmd = CMD_REF;
            wait_load = 1'b1;
            wait_value = rfc_of(cur_mode[2] ? 2'h0 : cur_rate);
         end
         ACT_SRE:
            next_cmd = CMD_SRE;
         ACT_EXIT:
         begin
            wait_load = 1'b1;
            wait_value = XS_CYC;
            interval_load = 1'b1;
         end
         default:
         begin
            if (state == ST_SELF)
               next_cmd.cke = 1'b0;
         end
      endcase
      if (action == ACT_SRE)
         next_state = ST_SELF;
      else if (wait_load)
         next_state = ST_WAIT;
      else if (state == ST_WAIT && wait_done)
         next_state = ST_IDLE;
   end

   // state and command pins
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state <= ST_IDLE;
         dram_cmd <= CMD_DES;
      end
      else
      begin
         state <= next_state;
         dram_cmd <= next_cmd;
      end
   end

   // applied mode register contents, fixed normal after reset
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cur_mode <= MODE_FIXED_1X;
         applied_tcr <= 1'b0;
         applied_ext <= 1'b0;
         init_mr3 <= 1'b1;
         init_mr4 <= 1'b1;
      end
      else if (action == ACT_MR3)
      begin
         cur_mode <= req_mode;
         init_mr3 <= 1'b0;
      end
      else if (action == ACT_MR4)
      begin
         applied_tcr <= tcr_target;
         applied_ext <= ctrl[CTRL_TCR_EXT_BIT];
         init_mr4 <= 1'b0;
      end
   end

   // fast refresh count and extras owed after self refresh
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         fast_cnt <= 2'h0;
         extra_cnt <= 3'h0;
         sr_misaligned <= 1'b0;
      end
      else
      begin
         case (action)
            ACT_ALIGN, ACT_REF:
               fast_cnt <= ref_fast ? fast_cnt + 2'h1 : 2'h0;
            ACT_MR3:
               if (rate_change)
                  fast_cnt <= 2'h0;
            ACT_EXTRA:
               extra_cnt <= extra_cnt - 3'h1;
            ACT_SRE:
               sr_misaligned <= !cur_aligned;
            ACT_EXIT:
            begin
               fast_cnt <= 2'h0;
               if (!sr_misaligned)
                  extra_cnt <= 3'h0;
               else if (cur_mode[2])
                  extra_cnt <= 3'h1;
               else if (cur_rate == 2'h1)
                  extra_cnt <= 3'h2;
               else
                  extra_cnt <= 3'h4;
            end
            default:
               fast_cnt <= fast_cnt;
         endcase
      end
   end

   // issued refresh statistics
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ref_total <= 16'h0000;
         last_fast <= 1'b0;
      end
      else if (action == ACT_REF || action == ACT_ALIGN)
      begin
         ref_total <= ref_total + 16'h0001;
         last_fast <= ref_fast;
      end
      else if (action == ACT_EXTRA)
         ref_total <= ref_total + 16'h0001;
   end

   // command spacing and refresh interval timers
   drr_down_timer #(.WIDTH(8)) u_wait (
      .pclk(pclk),
      .presetn(presetn),
      .load(wait_load),
      .value(wait_value),
      .done(wait_done)
   );

   drr_down_timer #(.WIDTH(8)) u_interval (
      .pclk(pclk),
      .presetn(presetn),
      .load(interval_load),
      .value(interval_value),
      .done(interval_done)
   );

   // status and read decode
   always_comb
   begin
      status_word = 32'h0000_0000;
      status_word[STAT_SELF_BIT] = (state == ST_SELF);
      status_word[STAT_INIT_DONE_BIT] = !init_mr3 && !init_mr4;
      status_word[STAT_MODE_PEND_BIT] = mr3_dirty || mr4_dirty;
      status_word[STAT_EXTRA_PEND_BIT] = (extra_cnt != 3'h0);
      status_word[STAT_FAST_CNT_LSB +: 2] = fast_cnt;
      status_word[STAT_MODE_LSB +: 3] = cur_mode;
      status_word[STAT_TCR_BIT] = applied_tcr;
      status_word[STAT_CONFLICT_BIT] = ctrl[CTRL_TCR_EN_BIT] && !tcr_target;
      status_word[STAT_LAST_FAST_BIT] = last_fast;
      addr_hit = 1'b1;
      read_word = 32'h0000_0000;
      if (12'(paddr) == CTRL_OFFSET)
         read_word = {24'h000000, ctrl};
      else if (12'(paddr) == STATUS_OFFSET)
         read_word = status_word;
      else if (12'(paddr) == COUNT_OFFSET)
         read_word = {16'h0000, ref_total};
      else
         addr_hit = 1'b0;
   end

   // apb slave, zero wait states, read data captured in setup, write data in access
   assign pready = 1'b1;
   assign pslverr = psel && penable && !addr_hit;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl <= CTRL_RESET;
         prdata <= 32'h0000_0000;
      end
      else
      begin
         if (psel && !penable && !pwrite)
            prdata <= read_word;
         if (psel && penable && pwrite && 12'(paddr) == CTRL_OFFSET)
            ctrl <= pwdata[7:0];
      end
   end

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   property p_ref_des;
      is_ref |=> dram_cmd.cs_n [*3];
   endproperty
   a_ref_des: assert property (p_ref_des)
      else $error("command issued inside refresh cycle time");

   property p_ref_after_mode;
      is_ref |-> !init_mr3 && !init_mr4;
   endproperty
   a_ref_after_mode: assert property (p_ref_after_mode)
      else $error("refresh before mode register writes");

   property p_sre_code;
      $fell(dram_cmd.cke) |-> !dram_cmd.cs_n && !dram_cmd.ras_n &&
         !dram_cmd.cas_n && dram_cmd.we_n && dram_cmd.act_n;
   endproperty
   a_sre_code: assert property (p_sre_code)
      else $error("bad self refresh entry encoding");

   property p_self_cke;
      state == ST_SELF |-> !dram_cmd.cke ##1 (state != ST_SELF ||
         !dram_cmd.cke);
   endproperty
   a_self_cke: assert property (p_self_cke)
      else $error("cke high during self refresh");

   property p_tcr_1x;
      applied_tcr |-> cur_mode == MODE_FIXED_1X;
   endproperty
   a_tcr_1x: assert property (p_tcr_1x)
      else $error("tcr on outside fixed normal mode");

   property p_even_change;
      action == ACT_MR3 && rate_change && cur_rate == 2'h1 |->
         !fast_cnt[0] ##1 fast_cnt == 2'h0;
   endproperty
   a_even_change: assert property (p_even_change)
      else $error("odd double count at rate change");

   property p_quad_change;
      action == ACT_MR3 && rate_change && cur_rate == 2'h2 |->
         fast_cnt == 2'h0;
   endproperty
   a_quad_change: assert property (p_quad_change)
      else $error("quad count not whole at rate change");

   property p_otf_pair;
      action == ACT_REF && cur_mode == MODE_OTF_1X2X && !ref_fast |=>
         is_ref && !dram_cmd.bank_group_bit_zero && !$past(fast_cnt[0]);
   endproperty
   a_otf_pair: assert property (p_otf_pair)
      else $error("normal refresh splits double pair");

   property p_otf_quad;
      action == ACT_REF && cur_mode == MODE_OTF_1X4X && !ref_fast |->
         fast_cnt == 2'h0;
   endproperty
   a_otf_quad: assert property (p_otf_quad)
      else $error("normal refresh splits quad group");

   property p_tcr_interval;
      interval_load && applied_tcr |-> interval_value <= TCR_CYC;
   endproperty
   a_tcr_interval: assert property (p_tcr_interval)
      else $error("tcr refresh interval too long");

endmodule
`default_nettype wire

// ==== rtl/drr_pkg.sv ====
package drr_pkg;

   // register offsets on the apb side
   localparam logic [11:0] CTRL_OFFSET = 12'h000;
   localparam logic [11:0] STATUS_OFFSET = 12'h004;
   localparam logic [11:0] COUNT_OFFSET = 12'h008;

   // control register fields
   localparam int CTRL_REF_EN_BIT = 0;
   localparam int CTRL_SR_REQ_BIT = 1;
   localparam int CTRL_TCR_EN_BIT = 2;
   localparam int CTRL_TCR_EXT_BIT = 3;
   localparam int CTRL_MODE_LSB = 4;
   localparam int CTRL_USE_FAST_BIT = 7;
   localparam logic [7:0] CTRL_RESET = 8'h01;

   // status register fields
   localparam int STAT_SELF_BIT = 0;
   localparam int STAT_INIT_DONE_BIT = 1;
   localparam int STAT_MODE_PEND_BIT = 2;
   localparam int STAT_EXTRA_PEND_BIT = 3;
   localparam int STAT_FAST_CNT_LSB = 4;
   localparam int STAT_MODE_LSB = 6;
   localparam int STAT_TCR_BIT = 9;
   localparam int STAT_CONFLICT_BIT = 10;
   localparam int STAT_LAST_FAST_BIT = 11;

   // fine_grain_refresh_mode encodings
   localparam logic [2:0] MODE_FIXED_1X = 3'h0;
   localparam logic [2:0] MODE_FIXED_2X = 3'h1;
   localparam logic [2:0] MODE_FIXED_4X = 3'h2;
   localparam logic [2:0] MODE_OTF_1X2X = 3'h5;
   localparam logic [2:0] MODE_OTF_1X4X = 3'h6;

   // mode register addressing and field positions
   localparam logic MR3_BG0 = 1'b0;
   localparam logic [1:0] MR3_BA = 2'h3;
   localparam logic MR4_BG0 = 1'b1;
   localparam logic [1:0] MR4_BA = 2'h0;
   localparam int MR3_RATE_LSB = 6;
   localparam int MR4_TCR_BIT = 3;
   localparam int MR4_RANGE_BIT = 2;

   // times in ns and derived cycle counts at 25 mhz
   localparam int CLK_PERIOD_NS = 40;
   localparam int REFI_BASE_NS = 7800;
   localparam int TCR_MAX_NS = 3900;
   localparam int RFC1_NS = 260;
   localparam int RFC2_NS = 160;
   localparam int RFC4_NS = 110;
   localparam int XS_EXTRA_NS = 10;
   localparam int MOD_NS = 240;
   localparam logic [7:0] REFI1_CYC = 8'(REFI_BASE_NS / CLK_PERIOD_NS);
   localparam logic [7:0] REFI2_CYC =
      8'(REFI_BASE_NS / (2 * CLK_PERIOD_NS));
   localparam logic [7:0] REFI4_CYC =
      8'(REFI_BASE_NS / (4 * CLK_PERIOD_NS));
   localparam logic [7:0] TCR_CYC = 8'(TCR_MAX_NS / CLK_PERIOD_NS);
   localparam logic [7:0] RFC1_CYC =
      8'((RFC1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [7:0] RFC2_CYC =
      8'((RFC2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [7:0] RFC4_CYC =
      8'((RFC4_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [7:0] XS_CYC =
      8'((RFC1_NS + XS_EXTRA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [7:0] MOD_CYC =
      8'((MOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   // command pins toward the dram
   typedef struct packed {
      logic cke;
      logic cs_n;
      logic act_n;
      logic ras_n;
      logic cas_n;
      logic we_n;
      logic bank_group_bit_zero;
      logic [1:0] ba;
      logic [13:0] addr;
   } drr_cmd_type;

   localparam drr_cmd_type CMD_DES = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1,
      1'b1, 1'b0, 2'h0, 14'h0000};
   localparam drr_cmd_type CMD_REF = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0,
      1'b1, 1'b0, 2'h0, 14'h0000};
   localparam drr_cmd_type CMD_SRE = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0,
      1'b1, 1'b0, 2'h0, 14'h0000};
   localparam drr_cmd_type CMD_MRS = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0,
      1'b0, 1'b0, 2'h0, 14'h0000};

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_WAIT = 3'b010,
      ST_SELF = 3'b100
   } drr_state_type;

   typedef enum logic [2:0] {
      ACT_NONE = 3'h0,
      ACT_MR4 = 3'h1,
      ACT_MR3 = 3'h2,
      ACT_ALIGN = 3'h3,
      ACT_EXTRA = 3'h4,
      ACT_SRE = 3'h5,
      ACT_REF = 3'h6,
      ACT_EXIT = 3'h7
   } drr_action_type;

endpackage

// ==== rtl/drr_down_timer.sv ====
`timescale 1ns/100ps
`default_nettype none
module drr_down_timer
   import drr_pkg::*;
#(
   parameter int WIDTH = 8
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic load,
   input wire logic [WIDTH-1:0] value,
   output logic done
);

   logic [WIDTH-1:0] count;

   // loadable down counter, parks at zero
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         count <= '0;
      else if (load)
         count <= value;
      else if (count != '0)
         count <= count - 1'b1;
   end

   assign done = (count == '0);

endmodule
`default_nettype wire

// ==== tb/drr_dram_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module drr_dram_model
   import drr_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire drr_cmd_type cmd,
   output logic [2:0] rate,
   output logic tcr_on,
   output logic self_on,
   output logic odt_on,
   output logic owed,
   output logic [15:0] refs,
   output logic [7:0] faults
);
   logic [2:0] fcnt;
   logic [7:0] gap;
   logic [8:0] since;
   logic armed;
   logic ext_range;
   logic quad;
   logic fast;
   logic misal;
   logic sel;

   // rate class: 0 normal, 1 double, 2 quad
   function automatic logic [1:0] cls(input logic [2:0] m);
      return (m == 3'h1 || m == 3'h5) ? 2'h1 :
         (m == 3'h2 || m == 3'h6) ? 2'h2 : 2'h0;
   endfunction

   // kind of the refresh on the pins and alignment of the fast count
   assign quad = cls(rate) == 2'h2;
   assign fast = (rate == 3'h1) | (rate == 3'h2)
      | (rate[2] & cmd.bank_group_bit_zero);
   assign misal = quad ? (fcnt[1:0] != 2'h0) : fcnt[0];
   assign sel = cmd.cke & ~cmd.cs_n & cmd.act_n & ~cmd.ras_n & ~cmd.cas_n;

   // command decode at each rising edge
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rate <= MODE_FIXED_1X;
         tcr_on <= 1'b0;
         ext_range <= 1'b0;
         self_on <= 1'b0;
         odt_on <= 1'b1;
         owed <= 1'b0;
         refs <= 16'h0000;
         faults <= 8'h00;
         fcnt <= 3'h0;
         gap <= 8'h00;
         since <= 9'h000;
         armed <= 1'b0;
      end
      else if (self_on)
      begin
         // internal timer keeps data until cke rises
         if (cmd.cke)
         begin
            self_on <= 1'b0;
            odt_on <= 1'b1;
            owed <= misal;
            fcnt <= 3'h0;
            gap <= XS_CYC;
            since <= 9'h000;
         end
      end
      else
      begin
         if (gap != 8'h00)
            gap <= gap - 8'h01;
         since <= since + 9'h001;
         if (armed && tcr_on && since > {1'b0, TCR_CYC} + 9'h004)
            faults <= faults + 8'h01;
         if (!cmd.cs_n && gap != 8'h00)
            faults <= faults + 8'h01;
         if (sel && cmd.we_n)
         begin
            // refresh: address pins ignored, counter is internal
            refs <= refs + 16'h0001;
            since <= 9'h000;
            armed <= tcr_on;
            gap <= !fast ? RFC1_CYC : quad ? RFC4_CYC : RFC2_CYC;
            if (fast)
            begin
               fcnt <= fcnt + 3'h1;
               if (quad ? fcnt[1:0] == 2'h3 : fcnt[0])
                  owed <= 1'b0;
            end
            else
            begin
               if (misal && rate[2])
                  faults <= faults + 8'h01;
               fcnt <= 3'h0;
               owed <= 1'b0;
            end
         end
         if (!cmd.cke && !cmd.cs_n && cmd.act_n && !cmd.ras_n
            && !cmd.cas_n && cmd.we_n)
         begin
            // entry taken at any refresh count
            self_on <= 1'b1;
            odt_on <= 1'b0;
            if (owed)
               faults <= faults + 8'h01;
         end
         if (sel && !cmd.we_n)
         begin
            gap <= MOD_CYC;
            if (cmd.ba == 2'h3 && !cmd.bank_group_bit_zero)
            begin
               rate <= cmd.addr[8:6];
               if (cls(cmd.addr[8:6]) != cls(rate))
               begin
                  if (misal)
                     faults <= faults + 8'h01;
                  fcnt <= 3'h0;
               end
               if (tcr_on && cmd.addr[8:6] != 3'h0)
                  faults <= faults + 8'h01;
            end
            if (cmd.ba == 2'h0 && cmd.bank_group_bit_zero)
            begin
               tcr_on <= cmd.addr[3];
               ext_range <= cmd.addr[3] & cmd.addr[2];
               armed <= 1'b0;
               if (cmd.addr[3] && rate != 3'h0)
                  faults <= faults + 8'h01;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ==== tb/dram_refresh_rate_self_refresh_test.sv ====
`timescale 1ns/100ps
`default_nettype none
module dram_refresh_rate_self_refresh_test
   import drr_pkg::*;
;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   drr_cmd_type dram_cmd;
   logic [2:0] rate;
   logic tcr_on, self_on, odt_on, owed;
   logic [15:0] refs;
   logic [7:0] faults;
   logic [31:0] q;
   logic e;
   int fails = 0;
   int checks_done = 0;
   logic [31:0] mv [0:6] = '{32'h11, 32'h21, 32'he1, 32'h61, 32'hd1,
      32'h51, 32'h01};
   logic [2:0] mr [0:6] = '{3'h1, 3'h2, 3'h6, 3'h6, 3'h5, 3'h5, 3'h0};
   logic [31:0] sv [0:2] = '{32'hd1, 32'h21, 32'h11};

   always #20 pclk = ~pclk;

   drr_refresh_ctrl #(.ADDR_W(12)) DUT (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .dram_cmd(dram_cmd));

   drr_dram_model dram (.pclk(pclk), .presetn(presetn), .cmd(dram_cmd),
      .rate(rate), .tcr_on(tcr_on), .self_on(self_on), .odt_on(odt_on),
      .owed(owed), .refs(refs), .faults(faults));

   // one apb transfer: setup, access until pready, release
   task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] rq, output logic er);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rq = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic check(input string what, input logic [31:0] exp,
      input logic [31:0] got);
      checks_done++;
      if (got !== exp)
      begin
         fails++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask

   // wait for k more refreshes on the pins
   task automatic wait_refs(input int k);
      logic [15:0] target;
      int n;
      target = refs + 16'(k);
      n = 0;
      while (refs !== target && n < k * 300 + 400)
      begin
         @(posedge pclk);
         n++;
      end
      check("refresh progress", {16'h0, target}, {16'h0, refs});
   endtask

   task automatic wait_self(input logic v);
      int n;
      n = 0;
      while (self_on !== v && n < 3000)
      begin
         @(posedge pclk);
         n++;
      end
      check("self refresh state", {31'h0, v}, {31'h0, self_on});
   endtask

   task automatic conclude;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // watchdog sized well past the sequence length
   initial
   begin
      repeat (60000) @(posedge pclk);
      fails++;
      $display("unexpected timeout: expected done seen hung");
      conclude();
   end

   // main sequence
   initial
   begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, CTRL_OFFSET, 32'h0, q, e);
      check("ctrl reset", {24'h0, CTRL_RESET}, q);
      apb(1'b0, 12'h00c, 32'h0, q, e);
      check("unmapped error", 32'h1, {31'h0, e});
      wait_refs(2);
      check("rate after init", 32'h0, {29'h0, rate});
      apb(1'b0, STATUS_OFFSET, 32'h0, q, e);
      check("init done", 32'h1, {31'h0, q[STAT_INIT_DONE_BIT]});
      // walk the rate modes, odd and misaligned counts included
      for (int i = 0; i < 7; i++)
      begin
         apb(1'b1, CTRL_OFFSET, mv[i], q, e);
         wait_refs(i == 1 ? 5 : 3);
         check("rate", {29'h0, mr[i]}, {29'h0, rate});
         check("faults", 32'h0, {24'h0, faults});
      end
      // self refresh with a misaligned fast count
      for (int i = 0; i < 3; i++)
      begin
         apb(1'b1, CTRL_OFFSET, sv[i], q, e);
         wait_refs(3);
         apb(1'b1, CTRL_OFFSET, sv[i] | 32'h2, q, e);
         wait_self(1'b1);
         check("termination", 32'h0, {31'h0, odt_on});
         repeat (40) @(posedge pclk);
         apb(1'b0, STATUS_OFFSET, 32'h0, q, e);
         check("held", 32'h1, {31'h0, q[STAT_SELF_BIT] & self_on});
         apb(1'b1, CTRL_OFFSET, sv[i], q, e);
         wait_self(1'b0);
         apb(1'b0, STATUS_OFFSET, 32'h0, q, e);
         check("owed", 32'h1, {31'h0, q[STAT_EXTRA_PEND_BIT]});
         wait_refs(4);
         check("extra refresh", 32'h0, {31'h0, owed});
         check("faults", 32'h0, {24'h0, faults});
      end
      // temperature scaling refused outside fixed normal rate
      apb(1'b1, CTRL_OFFSET, 32'h15, q, e);
      wait_refs(2);
      apb(1'b0, STATUS_OFFSET, 32'h0, q, e);
      check("tcr conflict", 32'h1, {31'h0, q[STAT_CONFLICT_BIT]});
      check("tcr off", 32'h0, {31'h0, tcr_on});
      apb(1'b1, CTRL_OFFSET, 32'h0d, q, e);
      wait_refs(4);
      apb(1'b0, STATUS_OFFSET, 32'h0, q, e);
      check("tcr applied", 32'h1, {31'h0, q[STAT_TCR_BIT]});
      check("tcr on", 32'h1, {31'h0, tcr_on});
      check("faults", 32'h0, {24'h0, faults});
      apb(1'b0, COUNT_OFFSET, 32'h0, q, e);
      check("refresh count", {16'h0, refs}, q);
      conclude();
   end
endmodule
`default_nettype wire
